/* rtl/sng_pkg.sv */
package sng_pkg;

  // ****************************************
  // Line rates, primitives and negotiation states
  // ****************************************
  typedef enum logic [1:0]
  {
    SNG_RATE_NONE = 2'h0,
    SNG_RATE_GEN1 = 2'h1,
    SNG_RATE_GEN2 = 2'h2,
    SNG_RATE_GEN3 = 2'h3
  } sng_rate_e;

  typedef enum logic [1:0]
  {
    SNG_TX_TONE = 2'h0,
    SNG_TX_ALIGN = 2'h1,
    SNG_TX_SYNC = 2'h2
  } sng_tx_e;

  typedef enum logic [1:0]
  {
    SNG_ST_TONE = 2'h0,
    SNG_ST_ALIGN = 2'h1,
    SNG_ST_IDLE = 2'h2
  } sng_state_e;

  // ****************************************
  // Counts and reset values
  // ****************************************
  localparam int SNG_CLK_MHZ = 100;
  localparam int SNG_RX_HOLD_NS = 40;
  localparam int SNG_RX_HOLD_CYC = (SNG_RX_HOLD_NS * SNG_CLK_MHZ + 999) / 1000;
  localparam int SNG_ALIGN_CNT = 4;
  localparam logic [1:0] SNG_RATE_RST = 2'h1;

endpackage

/* rtl/sng_rx_if.sv */
`timescale 1ns/1ps
interface sng_rx_if;
  import sng_pkg::*;
  logic align_ok;
  logic [1:0] align_rate;
  logic cominit;
  logic sync_seen;

  modport det
  (
    output align_ok,
    output align_rate,
    output cominit,
    output sync_seen
  );

  modport fsm
  (
    input align_ok,
    input align_rate,
    input cominit,
    input sync_seen
  );
endinterface

/* rtl/sng_rx_detect.sv */
`timescale 1ns/1ps
module sng_rx_detect
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Raw receive indications, already on clk_sys
  input wire logic align_in,
  input wire logic [1:0] rate_in,
  input wire logic cominit_in,
  input wire logic sync_in,
  // Qualified ALIGNp indications; cominit and sync_seen pass straight through
  sng_rx_if.det rx
);
  import sng_pkg::*;

  logic [1:0] rate_r;
  logic [1:0] rate_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic rate_supported;
  logic same_rate;

  // A GEN3 alias may look valid for a few words, so the rate must both be
  // supported and stay constant for several words before it counts.
  assign rate_supported = align_in && (rate_in == SNG_RATE_GEN1 || rate_in == SNG_RATE_GEN2);
  assign same_rate = rate_supported && rate_in == rate_r;
  assign rate_nxt = rate_supported ? rate_in : SNG_RATE_NONE;
  assign cnt_nxt = !rate_supported ? 3'h0 : (!same_rate ? 3'h1 :
                   (cnt_r == 3'(SNG_ALIGN_CNT) ? cnt_r : cnt_r + 3'h1));

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rate_r <= SNG_RATE_NONE;
      cnt_r <= 3'h0;
    end
    else
    begin
      rate_r <= rate_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign rx.align_ok = cnt_r == 3'(SNG_ALIGN_CNT);
  assign rx.align_rate = rate_r;
  assign rx.cominit = cominit_in;
  assign rx.sync_seen = sync_in;
endmodule

/* rtl/sng_host_neg.sv */
`timescale 1ns/1ps
module sng_host_neg
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Software port reset request
  input wire logic sw_reset,
  // Receive indications from the PHY, asynchronous to clk_sys
  input wire logic rx_align,
  input wire logic [1:0] rx_rate,
  input wire logic rx_cominit,
  input wire logic rx_sync,
  // Transmit control toward the PHY
  output logic [1:0] tx_kind,
  output logic [1:0] tx_rate,
  // Status
  output logic link_up
);
  import sng_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic [1:0] rate_s_r;
  logic [1:0] rate_pair;
  logic sw_meta_r;
  logic sw_sync_r;

  // The two rate bits may cross on different edges, so a rate only counts once
  // two successive synchronised samples agree; a torn pair reads as no rate.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
      rate_s_r <= 2'h0;
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= {rx_sync, rx_cominit, rx_rate, rx_align};
      sync_r <= meta_r;
      rate_s_r <= sync_r[2:1];
      sw_meta_r <= sw_reset;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ****************************************
  // Receive qualification
  // ****************************************
  sng_rx_if rx_q();

  assign rate_pair = (sync_r[2:1] == rate_s_r) ? rate_s_r : SNG_RATE_NONE;

  sng_rx_detect u_det
  (
    .clk_sys(clk_sys),
    .rst(rst || sw_sync_r),
    .align_in(sync_r[0]),
    .rate_in(rate_pair),
    .cominit_in(sync_r[3]),
    .sync_in(sync_r[4]),
    .rx(rx_q.det)
  );

  // ****************************************
  // Negotiation state machine
  // ****************************************
  sng_state_e state_r;
  sng_state_e state_nxt;
  logic [1:0] rate_r;
  logic [1:0] rate_nxt;
  logic [1:0] kind_nxt;
  logic [1:0] txr_nxt;
  logic restart;

  assign restart = sw_sync_r || rx_q.cominit;

  always_comb
  begin
    state_nxt = state_r;
    rate_nxt = rate_r;
    unique case (state_r)
      SNG_ST_TONE:
      begin
        if (rx_q.align_ok)
        begin
          state_nxt = SNG_ST_ALIGN;
          rate_nxt = rx_q.align_rate;
        end
      end
      SNG_ST_ALIGN:
      begin
        // Losing the target's ALIGNp at our rate means it stepped down;
        // return to the tone rather than stay parked at a stale rate.
        if (rx_q.sync_seen)
          state_nxt = SNG_ST_IDLE;
        else if (!rx_q.align_ok || rx_q.align_rate != rate_r)
        begin
          state_nxt = SNG_ST_TONE;
          rate_nxt = SNG_RATE_RST;
        end
      end
      SNG_ST_IDLE:
      begin
        state_nxt = SNG_ST_IDLE;
      end
      default:
      begin
        state_nxt = SNG_ST_TONE;
        rate_nxt = SNG_RATE_RST;
      end
    endcase
    if (restart)
    begin
      state_nxt = SNG_ST_TONE;
      rate_nxt = SNG_RATE_RST;
    end
  end

  assign kind_nxt = state_nxt == SNG_ST_TONE ? SNG_TX_TONE :
                    (state_nxt == SNG_ST_ALIGN ? SNG_TX_ALIGN : SNG_TX_SYNC);
  assign txr_nxt = state_nxt == SNG_ST_TONE ? SNG_RATE_GEN1 : rate_nxt;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= SNG_ST_TONE;
      rate_r <= SNG_RATE_RST;
      tx_kind <= SNG_TX_TONE;
      tx_rate <= SNG_RATE_GEN1;
      link_up <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rate_r <= rate_nxt;
      tx_kind <= kind_nxt;
      tx_rate <= txr_nxt;
      link_up <= state_nxt == SNG_ST_IDLE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_tone_gen1_rate: assert property (@(posedge clk_sys) disable iff (rst)
    tx_kind == SNG_TX_TONE |-> tx_rate == SNG_RATE_GEN1)
    else $error("tone sent at a rate other than GEN1");

  a_no_gen3_reply: assert property (@(posedge clk_sys) disable iff (rst)
    tx_kind != SNG_TX_TONE |-> tx_rate inside {SNG_RATE_GEN1, SNG_RATE_GEN2})
    else $error("host replied at an unsupported rate");

  a_align_same_rate: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == SNG_ST_TONE && rx_q.align_ok && !restart |=> tx_kind == SNG_TX_ALIGN
    && tx_rate == $past(rx_q.align_rate))
    else $error("ALIGNp reply rate differs from target rate");

  a_tone_until_ok: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == SNG_ST_TONE && !rx_q.align_ok |=> tx_kind == SNG_TX_TONE)
    else $error("left tone without recognised ALIGNp");

  a_sync_after_align: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == SNG_ST_ALIGN && rx_q.sync_seen && !restart |=> tx_kind == SNG_TX_SYNC && link_up)
    else $error("no SYNCp after negotiation");

  a_sw_reset_tone: assert property (@(posedge clk_sys) disable iff (rst)
    sw_sync_r |=> tx_kind == SNG_TX_TONE && !link_up)
    else $error("software reset did not restart negotiation");

  a_cominit_tone: assert property (@(posedge clk_sys) disable iff (rst)
    rx_q.cominit |=> tx_kind == SNG_TX_TONE && tx_rate == SNG_RATE_GEN1)
    else $error("COMINIT did not return host to tone");

  a_reset_start: assert property (@(posedge clk_sys)
    $fell(rst) |-> (tx_kind == SNG_TX_TONE && !link_up) [*2])
    else $error("negotiation not restarted after reset");

  // The first check below watches the qualified receive side on its own,
  // so a detector that let an aliased rate through would trip it as well.
  a_gen3_refused: assert property (@(posedge clk_sys) disable iff (rst)
    rx_q.align_ok |-> rx_q.align_rate inside {SNG_RATE_GEN1, SNG_RATE_GEN2})
    else $error("unsupported rate recognised as ALIGNp");

  a_align_rate_match: assert property (@(posedge clk_sys) disable iff (rst)
    tx_kind == SNG_TX_ALIGN && rx_q.align_ok |-> tx_rate == rx_q.align_rate)
    else $error("ALIGNp sent at a rate the target is not using");

  a_idle_holds: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == SNG_ST_IDLE && !restart |=> state_r == SNG_ST_IDLE && link_up)
    else $error("logical idle left without a restart");

  a_link_idle_only: assert property (@(posedge clk_sys) disable iff (rst)
    link_up |-> tx_kind == SNG_TX_SYNC && state_r == SNG_ST_IDLE)
    else $error("link reported up outside logical idle");

  a_sw_clears_detect: assert property (@(posedge clk_sys) disable iff (rst)
    sw_sync_r |=> !rx_q.align_ok)
    else $error("software reset left a recognised ALIGNp behind");

  a_cominit_rate: assert property (@(posedge clk_sys) disable iff (rst)
    rx_q.cominit |=> rate_r == SNG_RATE_RST && state_r == SNG_ST_TONE)
    else $error("COMINIT kept a partly negotiated rate");

endmodule

/* verif/sng_target_model.sv */
`timescale 1ns/1ps
module sng_target_model
#(
  parameter int TMO_CYC = 60
)
(
  // Clock and enable
  input wire logic clk_sys,
  input wire logic en,
  // Host transmit
  input wire logic [1:0] tx_kind,
  input wire logic [1:0] tx_rate,
  // Line toward host
  output logic rx_align,
  output logic [1:0] rx_rate,
  output logic rx_cominit,
  output logic rx_sync
);
  import sng_pkg::*;
  // ****
  // Target speed stepping
  // ****
  // The wait per rate is shortened; the stepping order is what matters here.
  int cnt;
  always @(negedge clk_sys)
  begin
    if (!en)
    begin
      rx_align <= 1'b0;
      rx_rate <= SNG_RATE_GEN3;
      rx_cominit <= 1'b0;
      rx_sync <= 1'b0;
      cnt <= 0;
    end
    else if (rx_sync)
      cnt <= 0;
    else if (tx_kind == SNG_TX_ALIGN && tx_rate == rx_rate)
      rx_sync <= 1'b1;
    else if (cnt == TMO_CYC)
    begin
      cnt <= 0;
      rx_cominit <= (rx_rate == SNG_RATE_GEN1);
      rx_rate <= (rx_rate == SNG_RATE_GEN1) ? SNG_RATE_GEN3 : rx_rate - 2'h1;
    end
    else
    begin
      cnt <= cnt + 1;
      rx_align <= 1'b1;
      rx_cominit <= 1'b0;
    end
  end
endmodule

/* verif/sng_host_neg_tb_top.sv */
`timescale 1ns/1ps
module sng_host_neg_tb_top;
  import sng_pkg::*;
  // ****
  // Stimulus and checks
  // ****
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sw_reset = 1'b0;
  logic use_model = 1'b0;
  logic b_align = 1'b0;
  logic [1:0] b_rate = 2'h0;
  logic b_cominit = 1'b0;
  logic b_sync = 1'b0;
  logic m_align, m_cominit, m_sync;
  logic [1:0] m_rate;
  wire logic rx_align = use_model ? m_align : b_align;
  wire logic [1:0] rx_rate = use_model ? m_rate : b_rate;
  wire logic rx_cominit = use_model ? m_cominit : b_cominit;
  wire logic rx_sync = use_model ? m_sync : b_sync;
  logic [1:0] tx_kind, tx_rate;
  logic link_up;
  int n_errors = 0;
  int total_checks = 0;
  // Rows: align, rate, expected kind, expected rate.
  logic [6:0] rows [5] = '{7'h71, 7'h41, 7'h55, 7'h11, 7'h66};
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  sng_host_neg dut_u (.clk_sys(clk_sys), .rst(rst), .sw_reset(sw_reset), .rx_align(rx_align),
    .rx_rate(rx_rate), .rx_cominit(rx_cominit), .rx_sync(rx_sync), .tx_kind(tx_kind),
    .tx_rate(tx_rate), .link_up(link_up));
  sng_target_model #(.TMO_CYC(60)) tgt_u (.clk_sys(clk_sys), .en(use_model), .tx_kind(tx_kind),
    .tx_rate(tx_rate), .rx_align(m_align), .rx_rate(m_rate), .rx_cominit(m_cominit), .rx_sync(m_sync));
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [1:0] kind, input logic [1:0] rate, input logic up, input string nm);
    total_checks++;
    if ({tx_kind, tx_rate, link_up} !== {kind, rate, up})
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, {tx_kind, tx_rate, link_up}, {kind, rate, up});
    end
    $display("test %s done", nm);
  endtask
  task automatic go_idle();
    b_align = 1'b1;
    b_rate = SNG_RATE_GEN2;
    wait_n(12);
    b_sync = 1'b1;
    wait_n(8);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_errors++;
    final_report();
  end
  initial
  begin
    wait_n(5);
    rst = 1'b0;
    chk(SNG_TX_TONE, SNG_RATE_GEN1, 1'b0, "reset");
    foreach (rows[i])
    begin
      b_align = rows[i][6];
      b_rate = rows[i][5:4];
      wait_n(12);
      chk(rows[i][3:2], rows[i][1:0], 1'b0, "row");
    end
    b_sync = 1'b1;
    wait_n(8);
    chk(SNG_TX_SYNC, SNG_RATE_GEN2, 1'b1, "sync");
    b_align = 1'b0;
    wait_n(12);
    chk(SNG_TX_SYNC, SNG_RATE_GEN2, 1'b1, "idle hold");
    b_cominit = 1'b1;
    wait_n(8);
    chk(SNG_TX_TONE, SNG_RATE_GEN1, 1'b0, "cominit");
    {b_cominit, b_sync} = 2'h0;
    go_idle();
    sw_reset = 1'b1;
    wait_n(8);
    chk(SNG_TX_TONE, SNG_RATE_GEN1, 1'b0, "sw reset");
    {sw_reset, b_sync} = 2'h0;
    go_idle();
    rst = 1'b1;
    wait_n(2);
    chk(SNG_TX_TONE, SNG_RATE_GEN1, 1'b0, "rst");
    {rst, b_sync, b_align} = 3'h0;
    use_model = 1'b1;
    wait_n(40);
    chk(SNG_TX_TONE, SNG_RATE_GEN1, 1'b0, "gen3 ignored");
    wait_n(80);
    chk(SNG_TX_SYNC, SNG_RATE_GEN2, 1'b1, "target link");
    final_report();
  end
endmodule
